// ### rdma_port.sv
// remote dma channel between local buffer memory and the host port latch,
// plus the host register slave handshake
// assumes all inputs except the slave chip select and strobes synchronous to sys_clk_i; memory answers with grant
`timescale 1ns/100ps
module rdma_port
    import rdma_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // command from the register file
    input wire logic start_i,
    input wire logic dir_write_i,
    input wire logic word_mode_i,
    input wire logic [ADDR_W-1:0] start_addr_i,
    input wire logic [ADDR_W-1:0] byte_count_i,
    output logic [ADDR_W-1:0] current_remote_address_o,
    output logic [ADDR_W-1:0] remote_byte_count_o,
    output logic busy_o,
    // local bus arbitration
    input wire logic local_dma_active_i,
    output logic local_bus_request_o,
    input wire logic local_bus_grant_i,
    // memory side
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic memory_write_strobe_o,
    output logic memory_read_strobe_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    // host port
    output logic port_request_o,
    input wire logic port_read_acknowledge_i,
    input wire logic host_io_write_strobe_i,
    input wire logic [DATA_W-1:0] port_data_i,
    output logic [DATA_W-1:0] port_data_o,
    output logic port_data_oe_o,
    output logic port_read_strobe_o,
    // host register slave
    input wire logic chip_select_n_i,
    input wire logic [IDX_W-1:0] register_index_lines_i,
    input wire logic slave_read_strobe_n_i,
    input wire logic slave_write_strobe_n_i,
    input wire logic address_latch_strobe_i,
    input wire logic mux_bus_i,
    input wire logic [7:0] slave_wdata_i,
    output logic slave_ack_n_o,
    output logic reg_access_o,
    output logic [IDX_W+8:0] reg_req_o
);
    rdma_state_e state_q, state_d;
    logic [ADDR_W-1:0] addr_q, count_q;
    logic [DATA_W-1:0] latch_q;
    logic prq_q, dir_q, word_q, full_q;
    logic fifo_valid, fifo_ready;
    logic [DATA_W-1:0] fifo_data;

    // step size picked by transfer width
    function automatic logic [ADDR_W-1:0] step_of(input logic word);
        step_of = word ? WORD_STEP : BYTE_STEP;
    endfunction

    wire [ADDR_W-1:0] step = step_of(word_q);
    wire count_last = count_q <= step;
    wire may_request = !local_dma_active_i;
    wire have_work = dir_q ? fifo_valid : !full_q;
    wire item_done = state_q == ST_MEM && local_bus_grant_i;
    wire host_write = host_io_write_strobe_i && prq_q && dir_q;
    wire host_read = port_read_acknowledge_i && prq_q && !dir_q;

    // remote write items pass through the fifo one at a time; the port request waits until it has drained
    rdma_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .in_valid_i(host_write),
        .in_ready_o(fifo_ready),
        .in_data_i(port_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(item_done && dir_q),
        .out_data_o(fifo_data)
    );

    // sequencer: wait, request bus, move one item, drop request
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (busy_o && have_work && may_request) state_d = ST_REQ;
            ST_REQ: state_d = ST_MEM;
            ST_MEM: if (!local_bus_grant_i && !may_request) state_d = ST_WAIT;
                else if (local_bus_grant_i) state_d = ST_PORT;
            ST_PORT: state_d = ST_IDLE;
            ST_WAIT: if (may_request) state_d = ST_REQ;
            default: state_d = ST_IDLE;
        endcase
    end

    assign busy_o = count_q != COUNT_RESET;
    assign local_bus_request_o = state_q == ST_MEM;
    assign mem_addr_o = addr_q;
    assign memory_read_strobe_o = item_done && !dir_q;
    assign memory_write_strobe_o = item_done && dir_q;
    assign port_read_strobe_o = item_done && dir_q;
    assign mem_wdata_o = fifo_data;
    assign port_data_o = latch_q;
    assign port_data_oe_o = !dir_q && full_q;
    assign port_request_o = prq_q;
    assign current_remote_address_o = addr_q;
    assign remote_byte_count_o = count_q;

    // channel registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            addr_q <= ADDR_RESET;
            count_q <= COUNT_RESET;
            dir_q <= 1'b0;
            word_q <= 1'b0;
        end else if (start_i && state_q == ST_IDLE) begin
            addr_q <= start_addr_i;
            count_q <= byte_count_i;
            dir_q <= dir_write_i;
            word_q <= word_mode_i;
        end else begin
            state_q <= state_d;
            if (item_done) begin
                addr_q <= addr_q + step;
                count_q <= count_last ? COUNT_RESET : count_q - step;
            end
        end
    end

    // port latch and request; a same-cycle refill beats the host strobe
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            latch_q <= '0;
            full_q <= 1'b0;
            prq_q <= 1'b0;
        end else if (!dir_q) begin
            if (item_done) begin
                latch_q <= mem_rdata_i;
                full_q <= 1'b1;
                prq_q <= 1'b1;
            end else if (host_read) begin
                full_q <= 1'b0;
                prq_q <= 1'b0;
            end
        end else begin
            full_q <= 1'b0;
            // withdrawn on host strobe, held low until the stored item has left for memory
            prq_q <= busy_o && fifo_ready && !host_write && !fifo_valid;
        end
    end

    // register slave: latch index, sync strobes, hold off while master
    logic [IDX_W-1:0] idx_q;
    logic [1:0] sync_q;
    logic cs_s1_q, cs_s2_q;
    reg_req_s req;
    wire strobe = !chip_select_n_i && (!slave_read_strobe_n_i || !slave_write_strobe_n_i);
    wire [IDX_W-1:0] idx_sel = mux_bus_i ? idx_q : register_index_lines_i;
    wire synced = sync_q == SYNC_LAST;
    assign req = '{index: idx_sel, write: !slave_write_strobe_n_i, wdata: slave_wdata_i};
    assign reg_req_o = req;
    assign reg_access_o = synced && !local_bus_request_o;
    assign slave_ack_n_o = !(cs_s2_q && synced && !local_bus_request_o);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            idx_q <= '0;
            sync_q <= 2'h0;
            cs_s1_q <= 1'b0;
            cs_s2_q <= 1'b0;
        end else begin
            if (address_latch_strobe_i) idx_q <= register_index_lines_i;
            cs_s1_q <= strobe;
            cs_s2_q <= cs_s1_q;
            if (!cs_s2_q) sync_q <= 2'h0;
            else if (!synced) sync_q <= sync_q + 2'h1;
        end
    end

    a_one_item_grant: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        item_done |=> !local_bus_request_o)
        else $error("bus request held after item");
    a_local_defers: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (state_q == ST_IDLE && local_dma_active_i) |=> state_q != ST_REQ)
        else $error("remote requested during local dma");
    a_read_raises_req: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (item_done && !dir_q && !start_i) |=> prq_q && full_q)
        else $error("no port request after fetch");
    a_ack_clears_req: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (host_read && !item_done) |=> !prq_q)
        else $error("read acknowledge ignored");
    a_write_drops_req: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (host_write && !start_i) |=> !prq_q)
        else $error("request kept after host write");
    a_count_advance: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (item_done && !start_i) |=> addr_q == $past(addr_q) + $past(step))
        else $error("address not advanced");
    a_zero_stops: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (!busy_o && state_q == ST_IDLE && !start_i) |=> state_q == ST_IDLE)
        else $error("channel ran at zero count");
    a_ack_sync: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(strobe) |-> slave_ack_n_o [*3])
        else $error("ack without synchronisation");
    a_ack_held_master: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        local_bus_request_o |-> slave_ack_n_o)
        else $error("ack while bus master");
endmodule

// ### rdma_pkg.sv
// package for the remote dma port channel: constants, states and carrier structs
// assumes one 20 MHz bus clock and synchronous active-high reset
package rdma_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SYNC_CYCLES = 2;
    localparam int IDX_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
    localparam logic [ADDR_W-1:0] BYTE_STEP = 16'h0001;
    localparam logic [1:0] SYNC_LAST = 2'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ = 3'b001,
        ST_MEM = 3'b011,
        ST_PORT = 3'b010,
        ST_WAIT = 3'b110
    } rdma_state_e;

    // one item moving through the channel
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] addr;
    } item_s;

    // host register access request
    typedef struct packed {
        logic [IDX_W-1:0] index;
        logic write;
        logic [7:0] wdata;
    } reg_req_s;
endpackage

// ### rdma_fifo.sv
// parameterised valid/ready fifo used in the remote write data path
// assumes a single clock and synchronous active-high reset
`timescale 1ns/100ps
module rdma_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wr_q;
    logic [PW:0] rd_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);

    // extra pointer bit tells full from empty
    assign in_ready_o = !full;
    assign out_valid_o = wr_q != rd_q;
    assign out_data_o = mem[rd_q[PW-1:0]];

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end

    // storage has no reset; only pointers define content
    always_ff @(posedge sys_clk_i) begin
        if (push) mem[wr_q[PW-1:0]] <= in_data_i;
    end
endmodule

// ### rdma_mem_model.sv
// local bus arbiter and buffer memory standing beside the remote dma channel
// assumes the channel's clock and synchronous active-high reset
`timescale 1ns/100ps
module rdma_mem_model (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic slow_i,
    input wire logic req_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic grant_o,
    output logic [15:0] rdata_o,
    output logic [31:0] last_wr_o
);
    logic [1:0] wait_q;
    // slow mode keeps the request pending three cycles before granting
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !req_i) begin
            wait_q <= 2'h0;
        end else if (wait_q != 2'h3) begin
            wait_q <= wait_q + 2'h1;
        end
    end
    // one stored item is remembered so the bench can judge it
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            last_wr_o <= 32'h0;
        end else if (wr_i) begin
            last_wr_o <= {addr_i, wdata_i};
        end
    end
    assign grant_o = req_i && (slow_i ? wait_q == 2'h3 : 1'b1);
    // data not being read is inverted so a stale sample cannot pass
    assign rdata_o = rd_i ? addr_i ^ 16'ha5c3 : ~(addr_i ^ 16'ha5c3);
endmodule

// ### remote_dma_port_and_slave_access_tb.sv
// self-checking bench for the remote dma port and register slave handshake
// assumes rdma_port, rdma_pkg and rdma_mem_model compiled before it
`timescale 1ns/100ps
module remote_dma_port_and_slave_access_tb;
    import rdma_pkg::*;
    int miscompares = 0;
    int num_checks = 0;
    logic sys_clk_i = 0, reset_i = 1, start_i = 0, dir_write_i = 0, word_mode_i = 0;
    logic local_dma_active_i = 0, port_read_acknowledge_i = 0, host_io_write_strobe_i = 0;
    logic chip_select_n_i = 1, slave_read_strobe_n_i = 1, slave_write_strobe_n_i = 1;
    logic address_latch_strobe_i = 0, mux_bus_i = 0, slow = 0, grant;
    logic [ADDR_W-1:0] start_addr_i = 0, byte_count_i = 0, current_remote_address_o;
    logic [ADDR_W-1:0] remote_byte_count_o, mem_addr_o;
    logic [DATA_W-1:0] mem_wdata_o, rdata, port_data_i = 0, port_data_o;
    logic busy_o, local_bus_request_o, memory_write_strobe_o, memory_read_strobe_o;
    logic port_request_o, port_data_oe_o, port_read_strobe_o, slave_ack_n_o, reg_access_o;
    logic [IDX_W-1:0] register_index_lines_i = 0;
    logic [7:0] slave_wdata_i = 0;
    logic [IDX_W+8:0] reg_req_o;
    logic [31:0] last_wr;
    rdma_port i_rdma_port (.sys_clk_i, .reset_i, .start_i, .dir_write_i, .word_mode_i,
        .start_addr_i, .byte_count_i, .current_remote_address_o, .remote_byte_count_o, .busy_o,
        .local_dma_active_i, .local_bus_request_o, .local_bus_grant_i(grant), .mem_addr_o,
        .memory_write_strobe_o, .memory_read_strobe_o, .mem_wdata_o, .mem_rdata_i(rdata),
        .port_request_o, .port_read_acknowledge_i, .host_io_write_strobe_i, .port_data_i,
        .port_data_o, .port_data_oe_o, .port_read_strobe_o, .chip_select_n_i,
        .register_index_lines_i, .slave_read_strobe_n_i, .slave_write_strobe_n_i,
        .address_latch_strobe_i, .mux_bus_i, .slave_wdata_i, .slave_ack_n_o, .reg_access_o,
        .reg_req_o);
    rdma_mem_model i_rdma_mem_model (.sys_clk_i, .reset_i, .slow_i(slow),
        .req_i(local_bus_request_o), .rd_i(memory_read_strobe_o), .wr_i(memory_write_strobe_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .grant_o(grant), .rdata_o(rdata),
        .last_wr_o(last_wr));
    initial forever #25 sys_clk_i = ~sys_clk_i;
    // inputs move 5 ns after each edge so no race with the design's sampling
    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk_i);
        #5;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // bounded wait: 0 port request, 1 slave ack, 2 channel idle
    task automatic wait_hi(int which);
        for (int i = 0; i < 60; i++) begin
            if ((which == 0 ? port_request_o : which == 1 ? !slave_ack_n_o : !busy_o) === 1'b1) return;
            tick();
        end
        miscompares++;
        summarize();
    endtask
    task automatic run_read(logic [15:0] a, logic defer);
        slow = defer;
        local_dma_active_i = defer;
        dir_write_i = 0;
        word_mode_i = 0;
        start_addr_i = a;
        byte_count_i = 16'h0002;
        start_i = 1;
        tick();
        start_i = 0;
        if (defer) begin
            repeat (8) begin
                tick();
                chk(local_bus_request_o, 16'h0);
            end
            local_dma_active_i = 0;
        end
        for (int k = 0; k < 2; k++) begin
            wait_hi(0);
            chk(port_data_o, (a + 16'(k)) ^ 16'ha5c3);
            chk(current_remote_address_o, a + 16'(k) + 16'h1);
            chk(remote_byte_count_o, 16'h1 - 16'(k));
            chk(local_bus_request_o, 16'h0);
            chk(port_data_oe_o, 16'h1);
            port_read_acknowledge_i = 1;
            tick();
            port_read_acknowledge_i = 0;
            tick();
            chk(port_request_o, 16'h0);
        end
        tick(4);
        chk(port_request_o, 16'h0);
        chk(busy_o, 16'h0);
    endtask
    task automatic run_write();
        slow = 1;
        dir_write_i = 1;
        word_mode_i = 1;
        start_addr_i = 16'h0200;
        byte_count_i = 16'h0004;
        start_i = 1;
        tick();
        start_i = 0;
        for (int k = 0; k < 2; k++) begin
            wait_hi(0);
            port_data_i = 16'hc0de + 16'(k);
            host_io_write_strobe_i = 1;
            tick();
            host_io_write_strobe_i = 0;
            port_data_i = ~port_data_i;
            tick();
            chk(port_request_o, 16'h0);
            wait_hi(k == 0 ? 0 : 2);
            chk(last_wr[31:16], 16'h0200 + 16'(2 * k));
            chk(last_wr[15:0], 16'hc0de + 16'(k));
        end
        chk(current_remote_address_o, 16'h0204);
        chk(remote_byte_count_o, 16'h0);
        chk(port_request_o, 16'h0);
        dir_write_i = 0;
    endtask
    // latched index mode changes the lines after the strobe to prove capture
    task automatic reg_access(logic wr, logic [3:0] idx, logic mux);
        mux_bus_i = mux;
        register_index_lines_i = idx;
        if (mux) begin
            address_latch_strobe_i = 1;
            tick();
            address_latch_strobe_i = 0;
            register_index_lines_i = ~idx;
        end
        chip_select_n_i = 0;
        slave_wdata_i = 8'h3c;
        slave_read_strobe_n_i = wr;
        slave_write_strobe_n_i = !wr;
        wait_hi(1);
        chk(reg_access_o, 16'h1);
        chk(16'(reg_req_o[12:8]), {11'h0, idx, wr});
        chip_select_n_i = 1;
        slave_read_strobe_n_i = 1;
        slave_write_strobe_n_i = 1;
        tick(4);
    endtask
    initial begin
        tick(10);
        reset_i = 0;
        run_read(16'h0100, 0);
        run_read(16'h0300, 1);
        // dummy read one below the write start, count two, so the request is set first
        run_read(16'h01ff, 0);
        run_write();
        reg_access(0, 4'h5, 0);
        reg_access(1, 4'h9, 0);
        reg_access(0, 4'ha, 1);
        summarize();
    end
endmodule
